//--- bench/risc8_execute_tb.sv
`timescale 1ns/1ps
module risc8_execute_tb;
  import exec_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic use_index = 1'b0;
  logic cond_true = 1'b0;
  logic dm_is_imm = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] opcode = OP_NOP;
  logic [15:0] target = 16'h0000;
  logic [7:0] src_value = 8'h00;
  logic [7:0] imm_data = 8'h00;
  logic [7:0] dm_addr = 8'h00;
  logic [3:0] dst_sel = 4'h0;
  logic [7:0] reg_wr_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_addr = 8'h00;
  wire logic [7:0] reg_rd_data, acc, dst_data, data_memory_addr, data_memory_wdata;
  wire logic [15:0] pc, program_memory_index;
  wire logic flag_c, flag_z, flag_v, global_interrupt_enable, dst_we, data_memory_we;
  wire logic [3:0] dst_addr;
  int err_count = 0;
  int compares = 0;
  logic [7:0] rv;
  // fields: op, source, carry in, result, carry out, register write
  localparam logic [23:0] TAB [21] = '{
    {OP_MOVE, 8'h00, 1'b1, 8'h00, 1'b1, 1'b1}, {OP_MOVE, 8'h9C, 1'b0, 8'h9C, 1'b0, 1'b1},
    {OP_CMVD, 8'h3C, 1'b0, 8'h3C, 1'b0, 1'b1}, {OP_CMVD, 8'h3C, 1'b1, 8'h3C, 1'b1, 1'b0},
    {OP_CMVS, 8'h3C, 1'b1, 8'h3C, 1'b1, 1'b1}, {OP_CMVS, 8'h3C, 1'b0, 8'h3C, 1'b0, 1'b0},
    {OP_SHL, 8'h81, 1'b0, 8'h02, 1'b1, 1'b1}, {OP_SHLC, 8'h40, 1'b1, 8'h81, 1'b0, 1'b1},
    {OP_SHR, 8'h81, 1'b1, 8'h40, 1'b1, 1'b1}, {OP_SHRC, 8'h02, 1'b1, 8'h81, 1'b0, 1'b1},
    {OP_SHRA, 8'h81, 1'b0, 8'hC0, 1'b1, 1'b1}, {OP_ONES_COMPLEMENT, 8'hFF, 1'b1, 8'h00, 1'b1, 1'b1},
    {OP_TWOS_COMPLEMENT_NEGATE, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1}, {OP_TWOS_COMPLEMENT_NEGATE, 8'h01, 1'b1, 8'hFF, 1'b0, 1'b1},
    {OP_NEGATE_WITH_CARRY_IN, 8'h00, 1'b1, 8'h00, 1'b1, 1'b1}, {OP_NEGATE_WITH_CARRY_IN, 8'h00, 1'b0, 8'hFF, 1'b0, 1'b1},
    {OP_INC, 8'hFF, 1'b0, 8'h00, 1'b1, 1'b1}, {OP_INCC, 8'hFF, 1'b1, 8'h00, 1'b1, 1'b1},
    {OP_INCC, 8'hFF, 1'b0, 8'hFF, 1'b0, 1'b1}, {OP_DEC, 8'h00, 1'b1, 8'hFF, 1'b0, 1'b1},
    {OP_DEC, 8'h01, 1'b0, 8'h00, 1'b1, 1'b1}};

  always #2.5 clk_sys = ~clk_sys;

  risc8_execute u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .instr_valid(instr_valid),
    .opcode(opcode), .use_index(use_index), .cond_true(cond_true), .target(target),
    .src_value(src_value), .dst_sel(dst_sel), .imm_data(imm_data), .dm_addr(dm_addr),
    .dm_is_imm(dm_is_imm), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .pc(pc), .program_memory_index(program_memory_index), .acc(acc), .flag_c(flag_c),
    .flag_z(flag_z), .flag_v(flag_v), .global_interrupt_enable(global_interrupt_enable),
    .dst_data(dst_data), .dst_addr(dst_addr), .dst_we(dst_we),
    .data_memory_addr(data_memory_addr), .data_memory_wdata(data_memory_wdata),
    .data_memory_we(data_memory_we));

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // returns just after the taken edge: write-back pulses stand only until the next edge
  task automatic ex(input logic [4:0] op, input logic [7:0] s = 8'h00,
      input logic [15:0] t = 16'h0000, input logic idx = 1'b0, input logic cc = 1'b0);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    opcode <= op;
    src_value <= s;
    dst_sel <= s[3:0];
    target <= t;
    use_index <= idx;
    cond_true <= cc;
    imm_data <= ~s;
    dm_addr <= s + 8'h01;
    dm_is_imm <= idx;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_wr_addr <= {4'h0, a};
    reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_rd_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask

  task automatic t_regs;
    rd({4'h0, REG_STAT}, rv);
    chk("stat", rv, STAT_RESET);
    chk("enable", global_interrupt_enable, 1'b0);
    wr(REG_ACC, 8'h55);
    rd({4'h0, REG_ACC}, rv);
    chk("acc read", rv, 8'h55);
  endtask

  task automatic t_flow;
    ex(OP_JUMP, 8'h00, 16'h1234);
    chk("pc jump", pc, 16'h1234);
    ex(OP_JCC, 8'h00, 16'h2000);
    chk("pc jcc false", pc, 16'h1235);
    ex(OP_JCC, 8'h00, 16'h2000, 1'b0, 1'b1);
    chk("pc jcc true", pc, 16'h2000);
    wr(REG_IPH, 8'h3A);
    wr(REG_IPL, 8'h5C);
    ex(OP_JCC, 8'h00, 16'h0000, 1'b1, 1'b1);
    chk("pc jcc index", pc, 16'h3A5C);
    ex(OP_CALL, 8'h00, 16'h4000);
    chk("pc call", pc, 16'h4000);
    ex(OP_CALL, 8'h00, 16'h5000);
    ex(OP_CALLS, 8'h00, 16'h6000);
    chk("pc fast call", pc, 16'h6000);
    chk("index fast call", program_memory_index, 16'h5001);
    ex(OP_RETS);
    chk("pc fast return", pc, 16'h5001);
    ex(OP_PUSH);
    chk("pc push", pc, 16'h5002);
    ex(OP_RET);
    chk("pc return", pc, 16'h5001);
    chk("enable before", global_interrupt_enable, 1'b0);
    ex(OP_RETI);
    chk("pc int return", pc, 16'h4001);
    chk("enable after", global_interrupt_enable, 1'b1);
    rd({4'h0, REG_STAT}, rv);
    chk("stat enable", rv, 8'h20);
    ex(OP_POP);
    chk("pc pop", pc, 16'h4002);
    chk("index pop", program_memory_index, 16'h3A5D);
  endtask

  task automatic t_alu;
    logic [23:0] e;
    for (int i = 0; i < 21; i++) begin
      e = TAB[i];
      // an increment of all ones or of zero presets the carry
      ex(OP_INC, e[10] ? 8'hFF : 8'h00);
      ex(e[23:19], e[18:11]);
      chk("acc", acc, e[9:2]);
      chk("carry", flag_c, e[1]);
      chk("zero", flag_z, e[9:2] == 8'h00);
      chk("dst_we", dst_we, e[0]);
      chk("dst_data", e[0] ? dst_data : 8'h00, e[0] ? e[9:2] : 8'h00);
      chk("dst_addr", e[0] ? dst_addr : 4'h0, e[0] ? e[14:11] : 4'h0);
      chk("dm_we", data_memory_we, 1'b0);
    end
  endtask

  task automatic t_dm;
    ex(OP_INC, 8'h7F);
    chk("overflow", flag_v, 1'b1);
    chk("acc inc", acc, 8'h80);
    ex(OP_MOVE_DM, 8'h5A, 16'h0000, 1'b1);
    chk("dm imm data", data_memory_wdata, 8'hA5);
    chk("dm addr", data_memory_addr, 8'h5B);
    chk("dm we", data_memory_we, 1'b1);
    chk("dst_we dm", dst_we, 1'b0);
    chk("acc kept", acc, 8'h80);
    chk("flags kept", {flag_v, flag_c, flag_z}, 3'b100);
    ex(OP_MOVE_DM, 8'h5A);
    chk("dm reg data", data_memory_wdata, 8'h5A);
    rd(8'h40, rv);
    chk("unmapped read", rv, 8'h04);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs;
    t_flow;
    t_alu;
    t_dm;
    test_done;
  end
endmodule

//--- logic/exec_pkg.sv
package exec_pkg;
  localparam int PC_W = 16;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam int GIE_BIT = 5;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // register file index of the accumulator and status, program index halves
  localparam logic [3:0] REG_IPH = 4'hC;
  localparam logic [3:0] REG_IPL = 4'hD;
  localparam logic [3:0] REG_STAT = 4'hE;
  localparam logic [3:0] REG_ACC = 4'hF;
  // opcodes of this execute stage
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_JUMP = 5'h01;
  localparam logic [4:0] OP_JCC = 5'h02;
  localparam logic [4:0] OP_CALL = 5'h03;
  localparam logic [4:0] OP_CALLS = 5'h04;
  localparam logic [4:0] OP_RET = 5'h05;
  localparam logic [4:0] OP_RETS = 5'h06;
  localparam logic [4:0] OP_RETI = 5'h07;
  localparam logic [4:0] OP_PUSH = 5'h08;
  localparam logic [4:0] OP_POP = 5'h09;
  localparam logic [4:0] OP_MOVE = 5'h0A;
  localparam logic [4:0] OP_MOVE_DM = 5'h0B;
  localparam logic [4:0] OP_CMVD = 5'h0C;
  localparam logic [4:0] OP_CMVS = 5'h0D;
  localparam logic [4:0] OP_SHL = 5'h0E;
  localparam logic [4:0] OP_SHLC = 5'h0F;
  localparam logic [4:0] OP_SHR = 5'h10;
  localparam logic [4:0] OP_SHRC = 5'h11;
  localparam logic [4:0] OP_SHRA = 5'h12;
  localparam logic [4:0] OP_ONES_COMPLEMENT = 5'h13;
  localparam logic [4:0] OP_TWOS_COMPLEMENT_NEGATE = 5'h14;
  localparam logic [4:0] OP_NEGATE_WITH_CARRY_IN = 5'h15;
  localparam logic [4:0] OP_INC = 5'h16;
  localparam logic [4:0] OP_INCC = 5'h17;
  localparam logic [4:0] OP_DEC = 5'h18;
endpackage

//--- logic/return_stack.sv
`timescale 1ns/1ps
module return_stack
  import exec_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [15:0] push_value,
  output logic [15:0] top
);
  logic [15:0] level [DEPTH];

  assign top = level[0];

  // one shift register level per entry; bottom fills with zero on pop
  for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        level[i] <= PC_RESET;
      end else if (push) begin
        level[i] <= (i == 0) ? push_value : level[(i == 0) ? 0 : i - 1];
      end else if (pop) begin
        level[i] <= (i == DEPTH - 1) ? PC_RESET : level[(i == DEPTH - 1) ? i : i + 1];
      end
    end
  end
endmodule

//--- logic/risc8_execute.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - jumps load pc, conditional only when true
// - call pushes pc+1 and jumps
// - fast call saves pc+1 in index
// - return pops pc; interrupt return sets enable
// - push advances pc, stacks index
// - pop advances pc, reloads index from stack
// - register move updates acc and zero
// - move on carry clear writes register
// - move on carry set writes register
// - left shift zero fill, carry bit 7
// - left rotate through carry
// - right shift zero fill, carry bit 0
// - right rotate through carry
// - arithmetic right shift keeps sign
// - ones complement affects zero only
// - negate sets carry on zero result
// - negate with carry in
// - increment carries on wrap to zero
// - increment with carry in
// - decrement clears carry on all ones
// - every instruction takes one cycle
// - zero flag tracks accumulator result
// - overflow flag on signed overflow
// - interrupt enable is status bit 5
module risc8_execute
  import exec_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [4:0] opcode,
  input wire logic use_index,
  input wire logic cond_true,
  input wire logic [15:0] target,
  input wire logic [7:0] src_value,
  input wire logic [3:0] dst_sel,
  input wire logic [7:0] imm_data,
  input wire logic [7:0] dm_addr,
  input wire logic dm_is_imm,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rd_addr,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  output logic [15:0] pc,
  output logic [15:0] program_memory_index,
  output logic [7:0] acc,
  output logic flag_c,
  output logic flag_z,
  output logic flag_v,
  output logic global_interrupt_enable,
  output logic [7:0] dst_data,
  output logic [3:0] dst_addr,
  output logic dst_we,
  output logic [7:0] data_memory_addr,
  output logic [7:0] data_memory_wdata,
  output logic data_memory_we
);
  // instructions execute in one cycle: everything is decoded combinationally
  logic [7:0] stat;
  logic [15:0] stack_top;
  logic [15:0] pc_next_seq;
  logic [15:0] jump_dest;
  logic [7:0] s;
  logic [7:0] inv_s;
  logic [8:0] inc_sum;
  logic [8:0] incc_sum;
  logic [8:0] neg_sum;
  logic [8:0] negc_sum;
  logic [7:0] dec_res;
  logic [15:0] next_pc;
  logic [15:0] next_ip;
  logic [7:0] next_acc;
  logic next_c;
  logic next_v;
  logic acc_wr;
  logic reg_dst_wr;
  logic stk_push;
  logic stk_pop;
  logic [15:0] push_val;
  logic go;

  assign go = instr_valid;
  assign s = src_value;
  assign inv_s = ~src_value;
  assign pc_next_seq = pc + PC_STEP;
  assign jump_dest = use_index ? program_memory_index : target;
  assign inc_sum = {1'b0, s} + 9'h001;
  assign incc_sum = {1'b0, s} + {8'h00, flag_c};
  assign neg_sum = {1'b0, inv_s} + 9'h001;
  assign negc_sum = {1'b0, inv_s} + {8'h00, flag_c};
  assign dec_res = s - 8'h01;
  assign global_interrupt_enable = stat[GIE_BIT];

  always_comb begin
    next_pc = pc_next_seq;
    next_ip = program_memory_index;
    next_acc = acc;
    next_c = flag_c;
    next_v = flag_v;
    acc_wr = 1'b0;
    reg_dst_wr = 1'b0;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    push_val = pc_next_seq;
    unique case (opcode)
      OP_JUMP: next_pc = jump_dest;
      OP_JCC: next_pc = cond_true ? jump_dest : pc_next_seq;
      OP_CALL: begin
        next_pc = jump_dest;
        stk_push = 1'b1;
      end
      OP_CALLS: begin
        next_pc = jump_dest;
        next_ip = pc_next_seq;
      end
      OP_RET, OP_RETI: begin
        next_pc = stack_top;
        stk_pop = 1'b1;
      end
      OP_RETS: next_pc = program_memory_index;
      OP_PUSH: begin
        stk_push = 1'b1;
        push_val = program_memory_index;
      end
      OP_POP: begin
        next_ip = stack_top;
        stk_pop = 1'b1;
      end
      OP_MOVE: begin
        next_acc = s;
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_CMVD: begin
        next_acc = s;
        acc_wr = 1'b1;
        reg_dst_wr = !flag_c;
      end
      OP_CMVS: begin
        next_acc = s;
        acc_wr = 1'b1;
        reg_dst_wr = flag_c;
      end
      OP_SHL, OP_SHLC: begin
        next_acc = {s[6:0], (opcode == OP_SHLC) ? flag_c : 1'b0};
        next_c = s[7];
        next_v = s[7] ^ s[6];
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_SHR, OP_SHRC, OP_SHRA: begin
        next_acc = {(opcode == OP_SHRC) ? flag_c : (opcode == OP_SHRA) ? s[7] : 1'b0,
                    s[7:1]};
        next_c = s[0];
        next_v = (opcode == OP_SHRC) ? (flag_c ^ s[7]) : 1'b0;
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_ONES_COMPLEMENT: begin
        next_acc = inv_s;
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_TWOS_COMPLEMENT_NEGATE: begin
        next_acc = neg_sum[7:0];
        next_c = (neg_sum[7:0] == BYTE_ZERO);
        next_v = (s == 8'h80);
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_NEGATE_WITH_CARRY_IN: begin
        next_acc = negc_sum[7:0];
        next_c = (negc_sum[7:0] == BYTE_ZERO) && flag_c;
        next_v = (inv_s == 8'h7F) && flag_c;
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_INC: begin
        next_acc = inc_sum[7:0];
        next_c = (inc_sum[7:0] == BYTE_ZERO);
        next_v = (s == 8'h7F);
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_INCC: begin
        next_acc = incc_sum[7:0];
        next_c = (incc_sum[7:0] == BYTE_ZERO) && flag_c;
        next_v = (s == 8'h7F) && flag_c;
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      OP_DEC: begin
        next_acc = dec_res;
        next_c = (dec_res != BYTE_ONES);
        next_v = (s == 8'h80);
        acc_wr = 1'b1;
        reg_dst_wr = 1'b1;
      end
      default: begin
      end
    endcase
  end

  return_stack #(.DEPTH(DEPTH)) u_stack (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .push(go && stk_push),
    .pop(go && stk_pop),
    .push_value(push_val),
    .top(stack_top)
  );

  // core state; a cycle without a valid instruction holds everything except register writes to IPH, IPL and ACC
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc <= PC_RESET;
      program_memory_index <= PC_RESET;
      acc <= BYTE_ZERO;
      flag_c <= 1'b0;
      flag_z <= 1'b0;
      flag_v <= 1'b0;
    end else if (go) begin
      pc <= next_pc;
      program_memory_index <= next_ip;
      acc <= next_acc;
      flag_c <= next_c;
      flag_v <= next_v;
      if (acc_wr) begin
        flag_z <= (next_acc == BYTE_ZERO);
      end
    end else if (reg_wr && reg_wr_addr[3:0] == REG_IPH) begin
      program_memory_index[15:8] <= reg_wr_data;
    end else if (reg_wr && reg_wr_addr[3:0] == REG_IPL) begin
      program_memory_index[7:0] <= reg_wr_data;
    end else if (reg_wr && reg_wr_addr[3:0] == REG_ACC) begin
      acc <= reg_wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat <= STAT_RESET;
    end else if (go && opcode == OP_RETI) begin
      stat[GIE_BIT] <= 1'b1;
    end else if (!go && reg_wr && reg_wr_addr[3:0] == REG_STAT) begin
      stat <= reg_wr_data;
    end
  end

  // register write-back and data memory port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dst_data <= BYTE_ZERO;
      dst_addr <= 4'h0;
      dst_we <= 1'b0;
      data_memory_addr <= BYTE_ZERO;
      data_memory_wdata <= BYTE_ZERO;
      data_memory_we <= 1'b0;
    end else begin
      dst_data <= next_acc;
      dst_addr <= dst_sel;
      dst_we <= go && reg_dst_wr;
      data_memory_addr <= dm_addr;
      data_memory_wdata <= dm_is_imm ? imm_data : s;
      data_memory_we <= go && (opcode == OP_MOVE_DM);
    end
  end

  // read port: index halves, status, accumulator; others read the v, c and z flags in bits 2 to 0
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rd_data <= BYTE_ZERO;
    end else if (reg_rd) begin
      unique case (reg_rd_addr[3:0])
        REG_IPH: reg_rd_data <= program_memory_index[15:8];
        REG_IPL: reg_rd_data <= program_memory_index[7:0];
        REG_STAT: reg_rd_data <= stat;
        REG_ACC: reg_rd_data <= acc;
        default: reg_rd_data <= {5'h00, flag_v, flag_c, flag_z};
      endcase
    end
  end

  chk_ret_pops: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_RET |=> pc == $past(stack_top))
    else $error("return did not load pc from stack");
  chk_reti_gie: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_RETI |=> global_interrupt_enable)
    else $error("interrupt return left enable clear");
  chk_call_push: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_CALL |=> stack_top == $past(pc) + PC_STEP)
    else $error("call did not stack next address");
  chk_calls_idx: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_CALLS && !use_index
    |=> program_memory_index == $past(pc) + PC_STEP && pc == $past(target))
    else $error("fast call wrong");
  chk_jcc_false: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_JCC && !cond_true |=> pc == $past(pc) + PC_STEP)
    else $error("untaken jump moved pc");
  chk_zero_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_MOVE |=> flag_z == (acc == BYTE_ZERO))
    else $error("zero flag mismatch");
  chk_inc_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_INC |=> flag_c == (acc == BYTE_ZERO))
    else $error("increment carry wrong");
  chk_cmvd_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_CMVD |=> dst_we == !$past(flag_c))
    else $error("carry clear move write wrong");
  chk_cmvs_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_CMVS |=> dst_we == $past(flag_c))
    else $error("carry set move write wrong");
  chk_jump_taken: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_JUMP && !use_index |=> pc == $past(target))
    else $error("jump did not load target");
  chk_push_index: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_PUSH |=> stack_top == $past(program_memory_index))
    else $error("push did not stack index");
  chk_pop_index: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_POP |=> program_memory_index == $past(stack_top))
    else $error("pop did not reload index");
  chk_dm_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_MOVE_DM |=> data_memory_we && acc == $past(acc))
    else $error("data memory store touched accumulator");
  chk_shl_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_SHL |=> flag_c == $past(src_value[7]) && !acc[0])
    else $error("left shift carry or fill wrong");
  chk_dec_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_DEC |=> flag_c == (acc != BYTE_ONES))
    else $error("decrement carry wrong");
  chk_ones_complement_flags: assert property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_ONES_COMPLEMENT |=> acc == ~$past(src_value) && flag_c == $past(flag_c))
    else $error("ones complement result or carry wrong");
  cov_call_ret: cover property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_CALL ##1 instr_valid && opcode == OP_RET);
  cov_jcc_taken: cover property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_JCC && cond_true);
  cov_inc_wrap: cover property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_INC && src_value == BYTE_ONES);
  cov_dm_imm: cover property (@(posedge clk_sys) disable iff (!arst_n)
    instr_valid && opcode == OP_MOVE_DM && dm_is_imm);
endmodule
